// ---- rtl/comparator_threshold_control.sv ----
// top of the comparator control: AXI4-Lite registers, analog selects,
// result synchronisation, shutdown request and interrupt
// assumes halt_mode comes from logic on aclk; comparator_raw is async
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
module comparator_threshold_control #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output var  logic              awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output var  logic              wready,
    output var  logic [1:0]        bresp,
    output var  logic              bvalid,
    input  wire logic              bready,
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output var  logic              arready,
    output var  logic [31:0]       rdata,
    output var  logic [1:0]        rresp,
    output var  logic              rvalid,
    input  wire logic              rready,
    input  wire logic              comparator_raw,
    input  wire logic              halt_mode,
    output var  logic              noninv_input_select,
    output var  logic              loop_select,
    output var  logic [5:0]        threshold_level_field,
    output var  logic              comparator_enable,
    output var  logic              pwm_shutdown_request,
    output var  logic              irq
);
    // =====================================================================
    // register state
    logic       comparator_enable_bit;
    logic       filter_disable_bit;
    logic [1:0] irq_mask;
    logic [1:0] irq_status;
    logic [1:0] clear_bits;
    logic       comp_active;

    logic              aw_held;
    logic              w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0]        w_byte;
    logic              w_lane;
    logic              do_write;
    logic              wr_hit;
    logic              do_read;
    logic              rd_hit;
    logic [7:0]        rd_byte;

    comp_event_if ev ();

    // =====================================================================
    // AXI4-Lite write path: address and data taken in either order
    assign awready  = !aw_held && !bvalid;
    assign wready   = !w_held && !bvalid;
    assign do_write = aw_held && w_held && !bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            aw_addr <= awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_byte <= 8'h00;
            w_lane <= 1'b0;
        end else if (wvalid && wready) begin
            w_held <= 1'b1;
            w_byte <= wdata[7:0];
            w_lane <= wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    always_comb begin
        wr_hit = 1'b1;
        unique case (aw_addr[7:0])
            comparator_threshold_pkg::COMP_CTRL_OFF:  wr_hit = 1'b1;
            comparator_threshold_pkg::DELAY_CTRL_OFF: wr_hit = 1'b1;
            comparator_threshold_pkg::CONV_CTRL2_OFF: wr_hit = 1'b1;
            comparator_threshold_pkg::IRQ_STATUS_OFF: wr_hit = 1'b1;
            comparator_threshold_pkg::IRQ_MASK_OFF:   wr_hit = 1'b1;
            default:                                  wr_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= comparator_threshold_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid <= 1'b1;
            bresp  <= wr_hit ? comparator_threshold_pkg::RESP_OKAY
                             : comparator_threshold_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // =====================================================================
    // control registers; level changes reach the pins at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            threshold_level_field <= comparator_threshold_pkg::LEVEL_RST;
            loop_select           <= comparator_threshold_pkg::LOOP_SEL_RST;
        end else if (do_write && w_lane &&
                     aw_addr[7:0] == comparator_threshold_pkg::COMP_CTRL_OFF)
        begin
            threshold_level_field <= w_byte[comparator_threshold_pkg::LEVEL_LSB
                +: comparator_threshold_pkg::LEVEL_W];
            loop_select <= w_byte[comparator_threshold_pkg::LOOP_SEL_BIT];
        end
    end

    // comparator starts off, delay filter starts on
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comparator_enable_bit <= comparator_threshold_pkg::COMP_EN_RST;
            filter_disable_bit    <=
                comparator_threshold_pkg::FILTER_DIS_RST;
        end else if (do_write && w_lane &&
                     aw_addr[7:0] == comparator_threshold_pkg::DELAY_CTRL_OFF)
        begin
            comparator_enable_bit <=
                w_byte[comparator_threshold_pkg::COMP_EN_BIT];
            filter_disable_bit    <=
                w_byte[comparator_threshold_pkg::FILTER_DIS_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            noninv_input_select <= comparator_threshold_pkg::NONINV_SEL_RST;
        end else if (do_write && w_lane &&
                     aw_addr[7:0] == comparator_threshold_pkg::CONV_CTRL2_OFF)
        begin
            noninv_input_select <=
                w_byte[comparator_threshold_pkg::NONINV_SEL_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask <= comparator_threshold_pkg::MASK_RST;
        end else if (do_write && w_lane &&
                     aw_addr[7:0] == comparator_threshold_pkg::IRQ_MASK_OFF)
        begin
            irq_mask <= w_byte[1:0];
        end
    end

    // write one to clear
    always_comb begin
        clear_bits = 2'h0;
        if (do_write && w_lane &&
            aw_addr[7:0] == comparator_threshold_pkg::IRQ_STATUS_OFF) begin
            clear_bits = w_byte[1:0];
        end
    end

    // =====================================================================
    // analog side: halt mode overrides the enable bit
    assign comp_active       = comparator_enable_bit && !halt_mode;
    assign comparator_enable = comp_active;

    comp_result_sync u_sync (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .comp_raw    (comparator_raw),
        .comp_active (comp_active),
        .ev          (ev)
    );

    // rising edges go to the delay filter only while it is enabled
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_shutdown_request <= 1'b0;
        end else begin
            pwm_shutdown_request <= ev.rise && !filter_disable_bit;
        end
    end

    comp_irq_ctrl #(
        .EV_W (comparator_threshold_pkg::EV_W)
    ) u_irq (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ev         (ev),
        .clear_bits (clear_bits),
        .mask       (irq_mask),
        .status     (irq_status),
        .irq        (irq)
    );

    // =====================================================================
    // AXI4-Lite read path
    assign arready = !rvalid;
    assign do_read = arvalid && arready;

    always_comb begin
        rd_byte = 8'h00;
        rd_hit  = 1'b1;
        unique case (araddr[7:0])
            comparator_threshold_pkg::COMP_CTRL_OFF: begin
                rd_byte = {threshold_level_field, loop_select,
                           ev.result};
            end
            comparator_threshold_pkg::DELAY_CTRL_OFF: begin
                rd_byte[comparator_threshold_pkg::COMP_EN_BIT] =
                    comparator_enable_bit;
                rd_byte[comparator_threshold_pkg::FILTER_DIS_BIT] =
                    filter_disable_bit;
            end
            comparator_threshold_pkg::CONV_CTRL2_OFF: begin
                rd_byte[comparator_threshold_pkg::NONINV_SEL_BIT] =
                    noninv_input_select;
            end
            comparator_threshold_pkg::IRQ_STATUS_OFF: rd_byte[1:0] = irq_status;
            comparator_threshold_pkg::IRQ_MASK_OFF:   rd_byte[1:0] = irq_mask;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0000_0000;
            rresp  <= comparator_threshold_pkg::RESP_OKAY;
        end else if (do_read) begin
            rvalid <= 1'b1;
            rdata  <= {24'h00_0000, rd_byte};
            rresp  <= rd_hit ? comparator_threshold_pkg::RESP_OKAY
                             : comparator_threshold_pkg::RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_noninv_write_lands: assert property (
        do_write && w_lane &&
        aw_addr[7:0] == comparator_threshold_pkg::CONV_CTRL2_OFF
        |=> noninv_input_select == $past(w_byte[6]))
        else $error("input select did not follow write");
    a_loop_write_lands: assert property (
        do_write && w_lane &&
        aw_addr[7:0] == comparator_threshold_pkg::COMP_CTRL_OFF
        |=> loop_select == $past(w_byte[1]))
        else $error("loop select did not follow write");
    a_level_applied_now: assert property (
        do_write && w_lane &&
        aw_addr[7:0] == comparator_threshold_pkg::COMP_CTRL_OFF
        |=> threshold_level_field == $past(w_byte[7:2]))
        else $error("threshold level not applied next cycle");
    a_result_readback: assert property (
        do_read && araddr[7:0] == comparator_threshold_pkg::COMP_CTRL_OFF
        |=> rvalid && rdata[0] == $past(ev.result)
            && rdata[7:2] == $past(threshold_level_field))
        else $error("control register readback wrong");
    a_reset_state: assert property (
        $rose(aresetn) |-> !comparator_enable && !filter_disable_bit)
        else $error("reset state of enables wrong");
    a_halt_disables: assert property (
        halt_mode |-> !comparator_enable ##1 !ev.result)
        else $error("comparator active in halt mode");
    a_shutdown_on_rise: assert property (
        ev.rise && !filter_disable_bit |=> pwm_shutdown_request)
        else $error("rising edge not forwarded to delay filter");
    a_filter_blocked: assert property (
        filter_disable_bit |=> !pwm_shutdown_request)
        else $error("shutdown request while filter disabled");
    a_off_result_low: assert property (
        !comparator_enable_bit[*2] |-> !ev.result)
        else $error("result not low while disabled");

    c_write_done: cover property (bvalid && bready);
    c_read_result: cover property (rvalid && rdata[0]);
    c_shutdown: cover property (pwm_shutdown_request);
endmodule
`default_nettype wire

// ---- rtl/comparator_threshold_pkg.sv ----
// constants for the comparator threshold control block
// assumes byte addressed 32-bit register words on an AXI4-Lite slave
package comparator_threshold_pkg;

    // =====================================================================
    // register byte offsets
    localparam logic [7:0] COMP_CTRL_OFF   = 8'hA0;
    localparam logic [7:0] DELAY_CTRL_OFF  = 8'hA4;
    localparam logic [7:0] CONV_CTRL2_OFF  = 8'hA8;
    localparam logic [7:0] IRQ_STATUS_OFF  = 8'hAC;
    localparam logic [7:0] IRQ_MASK_OFF    = 8'hB0;

    // =====================================================================
    // field positions
    localparam int LEVEL_LSB      = 2;
    localparam int LEVEL_W        = 6;
    localparam int LOOP_SEL_BIT   = 1;
    localparam int RESULT_BIT     = 0;
    localparam int COMP_EN_BIT    = 0;
    localparam int FILTER_DIS_BIT = 1;
    localparam int NONINV_SEL_BIT = 6;
    localparam int EV_RISE_BIT    = 0;
    localparam int EV_FALL_BIT    = 1;
    localparam int EV_W           = 2;

    // =====================================================================
    // reset values
    localparam logic [5:0] LEVEL_RST      = 6'h00;
    localparam logic       LOOP_SEL_RST   = 1'b0;
    localparam logic       COMP_EN_RST    = 1'b0;
    localparam logic       FILTER_DIS_RST = 1'b0;
    localparam logic       NONINV_SEL_RST = 1'b0;
    localparam logic [1:0] MASK_RST       = 2'h0;

    // =====================================================================
    // bus answers
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ---- rtl/comp_event_if.sv ----
// carries the synchronised comparator result and its edges
// assumes one clock domain shared by producer and consumer
`timescale 1ns/1ns
`default_nettype none
interface comp_event_if;
    logic result;
    logic rise;
    logic fall;

    modport src (output result, output rise, output fall);
    modport dst (input result, input rise, input fall);
endinterface
`default_nettype wire

// ---- rtl/comp_result_sync.sv ----
// synchronises the analog comparator output and finds its edges
// assumes comp_raw is asynchronous to aclk
`timescale 1ns/1ns
`default_nettype none
module comp_result_sync (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic comp_raw,
    input  wire logic comp_active,
    comp_event_if.src ev
);
    logic sync_a;
    logic sync_b;
    logic result;
    logic result_d;

    // =====================================================================
    // two stage synchroniser, first stage read only by the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= comp_raw;
            sync_b <= sync_a;
        end
    end

    // result forced low while the comparator is off
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            result   <= 1'b0;
            result_d <= 1'b0;
        end else begin
            result   <= sync_b & comp_active;
            result_d <= result;
        end
    end

    assign ev.result = result;
    assign ev.rise   = result & ~result_d;
    assign ev.fall   = ~result & result_d;

    // =====================================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_sync_high_path: assert property (
        (comp_raw && comp_active)[*3] |=> result)
        else $error("stable comparator high not seen after sync");
    a_inactive_low: assert property (
        !comp_active |=> !result && !ev.rise)
        else $error("result not held low while comparator off");
    c_rise_seen: cover property (ev.rise);
endmodule
`default_nettype wire

// ---- rtl/comp_irq_ctrl.sv ----
// sticky event status, mask and one level interrupt
// assumes clear pulses come from the bus slave on the same clock
`timescale 1ns/1ns
`default_nettype none
module comp_irq_ctrl #(
    parameter int EV_W = comparator_threshold_pkg::EV_W
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    comp_event_if.dst            ev,
    input  wire logic [EV_W-1:0] clear_bits,
    input  wire logic [EV_W-1:0] mask,
    output var  logic [EV_W-1:0] status,
    output var  logic            irq
);
    logic [EV_W-1:0] events;

    always_comb begin
        events = '0;
        events[comparator_threshold_pkg::EV_RISE_BIT] = ev.rise;
        events[comparator_threshold_pkg::EV_FALL_BIT] = ev.fall;
    end

    // =====================================================================
    // a new event wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status <= '0;
        end else begin
            status <= (status & ~clear_bits) | events;
        end
    end

    // level straight from the flops, so a mask write shows at once
    assign irq = |(status & mask);

    // =====================================================================
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_set_beats_clear: assert property (
        ev.rise && clear_bits[0] |=> status[0])
        else $error("rise event lost under a clear");
    a_irq_follows: assert property (
        (ev.rise && mask[0]) ##1 mask[0] |-> irq)
        else $error("interrupt low after unmasked event");
    c_irq_raised: cover property ($rose(irq));
endmodule
`default_nettype wire

// ---- testbench/analog_comparator_model.sv ----
// behavioural analog comparator in front of the control block
// assumes all voltages are 8-bit codes on one common scale
`timescale 1ns/1ns
`default_nettype none
module analog_comparator_model (
    input  wire logic       comparator_enable,
    input  wire logic       noninv_input_select,
    input  wire logic       loop_select,
    input  wire logic [5:0] threshold_level_field,
    input  wire logic [7:0] first_analog_pin,
    input  wire logic [7:0] second_analog_pin,
    input  wire logic [7:0] error_amp_output,
    output var  logic       comparator_raw
);
    // =====================================================================
    // comparison
    logic [7:0] vplus;
    logic [7:0] vminus;

    always_comb begin
        vplus = noninv_input_select ? second_analog_pin
                                    : first_analog_pin;
        vminus = loop_select ? error_amp_output
                             : {threshold_level_field, 2'b00};
        // a powered-down comparator reads low
        comparator_raw = comparator_enable && (vplus > vminus);
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the comparator threshold control block
// assumes the analog model stands on the comparator side
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [7:0] CTRL = comparator_threshold_pkg::COMP_CTRL_OFF;
    localparam logic [7:0] DLY  = comparator_threshold_pkg::DELAY_CTRL_OFF;
    localparam logic [7:0] CV2  = comparator_threshold_pkg::CONV_CTRL2_OFF;
    localparam logic [7:0] STS  = comparator_threshold_pkg::IRQ_STATUS_OFF;
    localparam logic [7:0] MSK  = comparator_threshold_pkg::IRQ_MASK_OFF;
    localparam logic [1:0] OKAY = comparator_threshold_pkg::RESP_OKAY;
    localparam logic [1:0] SERR = comparator_threshold_pkg::RESP_SLVERR;

    logic        aclk;
    logic        aresetn;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        comparator_raw;
    logic        halt_mode;
    logic        noninv_input_select;
    logic        loop_select;
    logic [5:0]  threshold_level_field;
    logic        comparator_enable;
    logic        pwm_shutdown_request;
    logic        irq;
    logic [7:0]  pin_a;
    logic [7:0]  pin_b;
    logic [7:0]  amp_out;
    logic [5:0]  lvl;
    logic [1:0]  exp_b[$];
    logic [33:0] exp_r[$];
    logic        exp_pwm[$];
    int          err_total;
    int          n_compared;
    integer      seed;

    comparator_threshold_control uut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .comparator_raw(comparator_raw), .halt_mode(halt_mode),
        .noninv_input_select(noninv_input_select),
        .loop_select(loop_select),
        .threshold_level_field(threshold_level_field),
        .comparator_enable(comparator_enable),
        .pwm_shutdown_request(pwm_shutdown_request), .irq(irq));

    analog_comparator_model partner (.comparator_enable(comparator_enable),
        .noninv_input_select(noninv_input_select),
        .loop_select(loop_select),
        .threshold_level_field(threshold_level_field),
        .first_analog_pin(pin_a), .second_analog_pin(pin_b),
        .error_amp_output(amp_out), .comparator_raw(comparator_raw));

    // =====================================================================
    // checking and closing
    task automatic check_bus(input string what, input logic [33:0] e,
                             input logic [33:0] g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_pin(input string what, input logic e,
                             input logic g);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    function automatic logic [33:0] cw(logic [5:0] l, logic lp, logic r);
        return {OKAY, 24'h0, l, lp, r};
    endfunction

    // =====================================================================
    // bus master
    task automatic bus_write(input logic [7:0] a, input logic [31:0] d,
                             input logic [1:0] er);
        int n;
        @(posedge aclk);
        exp_b.push_back(er);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        if (n == 40) begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic bus_read(input logic [7:0] a, input logic [33:0] e);
        int n;
        @(posedge aclk);
        exp_r.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        if (n == 40) begin
            err_total++;
            report_and_stop();
        end
    endtask

    // comparator path needs three edges, pulse and status one more
    task automatic settle;
        repeat (6) @(posedge aclk);
    endtask

    // =====================================================================
    // result monitor
    always @(posedge aclk) begin
        if (bvalid && bready) check_bus("bresp",
            {32'h0000_0000, exp_b.pop_front()}, {32'h0000_0000, bresp});
        if (rvalid && rready) check_bus("rdata", exp_r.pop_front(),
                                        {rresp, rdata});
        if (pwm_shutdown_request) begin
            check_pin("pwm_shutdown_request", exp_pwm.size() > 0, 1'b1);
            if (exp_pwm.size() > 0) void'(exp_pwm.pop_front());
        end
    end

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    // =====================================================================
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        {halt_mode, err_total, n_compared} = '0;
        wstrb = 4'hf;
        seed = 32'h94ad;
        pin_a = 8'd200;
        pin_b = 8'd20;
        amp_out = 8'd100;
        lvl = 6'd10;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        check_pin("comparator_enable", 1'b0, comparator_enable);
        bus_read(CTRL, cw(6'h0, 1'b0, 1'b0));
        bus_read(DLY, {OKAY, 32'h0});
        bus_read(CV2, {OKAY, 32'h0});
        bus_read(8'hc4, {SERR, 32'h0});
        bus_write(8'hc4, 32'hff, SERR);
        bus_write(CTRL, {24'h0, lvl, 2'b11}, OKAY);
        check_pin("loop_select", 1'b1, loop_select);
        bus_read(CTRL, cw(lvl, 1'b1, 1'b0));
        bus_write(MSK, 32'h3, OKAY);
        exp_pwm.push_back(1'b1);
        bus_write(DLY, 32'h1, OKAY);
        settle();
        check_pin("irq", 1'b1, irq);
        bus_read(CTRL, cw(lvl, 1'b1, 1'b1));
        bus_read(STS, {OKAY, 32'h1});
        $display("test enable done");
        bus_write(CTRL, {24'h0, 6'd55, 2'b00}, OKAY);
        settle();
        bus_read(CTRL, cw(6'd55, 1'b0, 1'b0));
        bus_write(STS, 32'h3, OKAY);
        settle();
        check_pin("irq", 1'b0, irq);
        pin_b <= 8'd230;
        exp_pwm.push_back(1'b1);
        bus_write(CV2, 32'h40, OKAY);
        settle();
        check_pin("noninv_input_select", 1'b1, noninv_input_select);
        bus_read(CTRL, cw(6'd55, 1'b0, 1'b1));
        bus_write(CTRL, {24'h0, 6'd55, 2'b10}, OKAY);
        amp_out <= 8'd250;
        settle();
        bus_read(CTRL, cw(6'd55, 1'b1, 1'b0));
        bus_write(DLY, 32'h3, OKAY);
        amp_out <= 8'd50;
        settle();
        bus_read(STS, {OKAY, 32'h3});
        $display("test selects and filter done");
        bus_write(DLY, 32'h1, OKAY);
        halt_mode <= 1'b1;
        settle();
        check_pin("comparator_enable", 1'b0, comparator_enable);
        bus_read(CTRL, cw(6'd55, 1'b1, 1'b0));
        exp_pwm.push_back(1'b1);
        halt_mode <= 1'b0;
        repeat (12) @(posedge aclk);
        bus_read(CTRL, cw(6'd55, 1'b1, 1'b1));
        bus_write(STS, 32'h3, OKAY);
        bus_write(MSK, 32'h0, OKAY);
        amp_out <= 8'd250;
        settle();
        check_pin("irq", 1'b0, irq);
        bus_write(MSK, 32'h2, OKAY);
        settle();
        check_pin("irq", 1'b1, irq);
        $display("test halt and mask done");
        bus_write(DLY, 32'h3, OKAY);
        repeat (8) begin
            lvl = 6'($random(seed));
            pin_b <= 8'($random(seed)) | 8'h1;
            bus_write(CTRL, {24'h0, lvl, 2'b00}, OKAY);
            check_pin("level", 1'b1, threshold_level_field === lvl);
            settle();
            bus_read(CTRL, cw(lvl, 1'b0, pin_b > {lvl, 2'b00}));
        end
        settle();
        check_pin("pulses left", 1'b0, exp_pwm.size() > 0);
        $display("test random levels done");
        report_and_stop();
    end
endmodule
`default_nettype wire
